// ===== rtl/ccds_config_regs.sv
// Codec control register file with reset defaults, update hold and control-frame pacing
//
// Operation
// - Loopbacks, power-down, soft reset come up deasserted
// - Input and output PGAs reset to 0 dB
// - Codec 1 handset paths, codec 2 line paths
// - Preamps 14 dB, microphone 32 dB
// - Speaker driver powered down after reset
// - Clock select: 8 kHz from 24.576 MHz
// - Handset/headset outputs on, echo -12 dB
// - Data-valid flag inserted in ADC words
// - Line in/out, reference on, analog powered
// - Control slot carried every frame after reset
// - Gain writes take effect immediately by default
// - Register 17 counts control-free frames between
// - Update bit 2 holds ADC, DAC and amp writes until cleared
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ccds_config_regs #(
  parameter int ADDR_W = 8,
  parameter logic [3:0] VERSION = ccds_pkg::VERSION_DEFAULT // Arbitrary value
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial frame timing
  input wire logic frame_sync,
  output logic ctrl_frame,
  // Codec settings
  output logic [7:0] set_c1_ctrl,
  output logic [7:0] set_c2_ctrl,
  output logic [7:0] set_c1_adc,
  output logic [7:0] set_c1_dac,
  output logic [7:0] set_c1_out,
  output logic [7:0] set_c2_adc,
  output logic [7:0] set_c2_dac,
  output logic [7:0] set_c2_out,
  output logic [7:0] set_amp,
  output logic [7:0] set_clk,
  output logic [7:0] set_mic_spk,
  output logic [7:0] set_line,
  output logic [7:0] set_c1_mode,
  output logic [7:0] set_c2_mode
);

  // Written register values
  logic [7:0] c1_ctrl_r;
  logic [7:0] c2_ctrl_r;
  logic [7:0] c1_adc_r;
  logic [7:0] c1_dac_r;
  logic [7:0] c1_out_r;
  logic [7:0] c2_adc_r;
  logic [7:0] c2_dac_r;
  logic [7:0] c2_out_r;
  logic [7:0] amp_r;
  logic [7:0] clk_r;
  logic [7:0] mic_spk_r;
  logic [7:0] line_r;
  logic [7:0] c1_mode_r;
  logic [7:0] c2_mode_r;
  logic [7:0] frame_skip_r;
  logic [7:0] upd_r;

  // Bus side
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata_nxt;
  logic hit_nxt;
  logic [4:0] idx;
  logic aligned;
  logic access;
  logic wr_stb;

  // Frame pacing
  logic [7:0] skip_cnt_r;
  logic ctrl_frame_r;

  // Working gains
  logic [7:0] c1_adc_act;
  logic [7:0] c1_dac_act;
  logic [7:0] c2_adc_act;
  logic [7:0] c2_dac_act;
  logic [7:0] amp_act;
  logic hold;

  // Registered settings outputs
  logic [7:0] set_c1_ctrl_r;
  logic [7:0] set_c2_ctrl_r;
  logic [7:0] set_c1_adc_r;
  logic [7:0] set_c1_dac_r;
  logic [7:0] set_c1_out_r;
  logic [7:0] set_c2_adc_r;
  logic [7:0] set_c2_dac_r;
  logic [7:0] set_c2_out_r;
  logic [7:0] set_amp_r;
  logic [7:0] set_clk_r;
  logic [7:0] set_mic_spk_r;
  logic [7:0] set_line_r;
  logic [7:0] set_c1_mode_r;
  logic [7:0] set_c2_mode_r;

  assign idx = paddr[6:2];
  assign aligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:7] == '0);
  assign access = psel && penable && !pready_r;
  // Registers are byte wide, so only lane 0 carries a write
  assign wr_stb = psel && penable && pready_r && pwrite && !pslverr_r && pstrb[0];
  assign hold = upd_r[ccds_pkg::UPD_HOLD_BIT];

  // Read mux and decode
  always_comb begin
    rdata_nxt = ccds_pkg::RDATA_ZERO;
    hit_nxt = aligned;
    case (idx)
      ccds_pkg::IDX_C1_CTRL: rdata_nxt[7:0] = c1_ctrl_r;
      ccds_pkg::IDX_C1_ADC: rdata_nxt[7:0] = c1_adc_r;
      ccds_pkg::IDX_C1_DAC: rdata_nxt[7:0] = c1_dac_r;
      ccds_pkg::IDX_C1_OUT: rdata_nxt[7:0] = c1_out_r;
      ccds_pkg::IDX_C2_CTRL: rdata_nxt[7:0] = c2_ctrl_r;
      ccds_pkg::IDX_C2_ADC: rdata_nxt[7:0] = c2_adc_r;
      ccds_pkg::IDX_C2_DAC: rdata_nxt[7:0] = c2_dac_r;
      ccds_pkg::IDX_C2_OUT: rdata_nxt[7:0] = c2_out_r;
      ccds_pkg::IDX_AMP: rdata_nxt[7:0] = amp_r;
      ccds_pkg::IDX_CLK: rdata_nxt[7:0] = clk_r;
      ccds_pkg::IDX_MIC_SPK: rdata_nxt[7:0] = mic_spk_r;
      ccds_pkg::IDX_LINE: rdata_nxt[7:0] = line_r;
      ccds_pkg::IDX_C1_MODE: rdata_nxt[7:0] = c1_mode_r;
      ccds_pkg::IDX_C2_MODE: rdata_nxt[7:0] = c2_mode_r;
      ccds_pkg::IDX_FRAME_SKIP: rdata_nxt[7:0] = frame_skip_r;
      ccds_pkg::IDX_UPDATE: rdata_nxt[7:0] = upd_r;
      default: begin
        // Reserved 18..20 read zero; anything else is unmapped
        hit_nxt = aligned && (idx >= ccds_pkg::IDX_RSVD_LO) && (idx <= ccds_pkg::IDX_RSVD_HI);
      end
    endcase
  end

  // One wait state: answer on the second access edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= ccds_pkg::RDATA_ZERO;
    end else begin
      pready_r <= access;
      pslverr_r <= access && !hit_nxt;
      if (access && !pwrite && hit_nxt) begin
        prdata_r <= rdata_nxt;
      end else if (access) begin
        prdata_r <= ccds_pkg::RDATA_ZERO;
      end
    end
  end

  // Codec control and path registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c1_ctrl_r <= ccds_pkg::RST_CTRL;
      c2_ctrl_r <= ccds_pkg::RST_CTRL;
      c1_out_r <= ccds_pkg::RST_C1_OUT;
      c2_out_r <= ccds_pkg::RST_C2_OUT;
      c1_mode_r <= ccds_pkg::RST_MODE;
      c2_mode_r <= ccds_pkg::RST_MODE;
    end else if (wr_stb) begin
      case (idx)
        ccds_pkg::IDX_C1_CTRL: c1_ctrl_r <= pwdata[7:0];
        ccds_pkg::IDX_C2_CTRL: c2_ctrl_r <= pwdata[7:0];
        ccds_pkg::IDX_C1_OUT: c1_out_r <= pwdata[7:0];
        ccds_pkg::IDX_C2_OUT: c2_out_r <= pwdata[7:0];
        ccds_pkg::IDX_C1_MODE: c1_mode_r <= pwdata[7:0];
        ccds_pkg::IDX_C2_MODE: c2_mode_r <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Gain registers, applied through the hold stage
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      c1_adc_r <= ccds_pkg::RST_C1_ADC;
      c1_dac_r <= ccds_pkg::RST_DAC;
      c2_adc_r <= ccds_pkg::RST_C2_ADC;
      c2_dac_r <= ccds_pkg::RST_DAC;
      amp_r <= ccds_pkg::RST_AMP;
    end else if (wr_stb) begin
      case (idx)
        ccds_pkg::IDX_C1_ADC: c1_adc_r <= pwdata[7:0];
        ccds_pkg::IDX_C1_DAC: c1_dac_r <= pwdata[7:0];
        ccds_pkg::IDX_C2_ADC: c2_adc_r <= pwdata[7:0];
        ccds_pkg::IDX_C2_DAC: c2_dac_r <= pwdata[7:0];
        ccds_pkg::IDX_AMP: amp_r <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Clock, output driver and analog enable registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clk_r <= ccds_pkg::RST_CLK;
      mic_spk_r <= ccds_pkg::RST_MIC_SPK;
      line_r <= ccds_pkg::RST_LINE;
    end else if (wr_stb) begin
      case (idx)
        ccds_pkg::IDX_CLK: clk_r <= pwdata[7:0];
        ccds_pkg::IDX_MIC_SPK: mic_spk_r <= pwdata[7:0];
        ccds_pkg::IDX_LINE: line_r <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Pacing and update-control registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_skip_r <= ccds_pkg::RST_FRAME_SKIP;
      upd_r <= {VERSION, ccds_pkg::RST_UPD_LOW[3:0]};
    end else if (wr_stb) begin
      if (idx == ccds_pkg::IDX_FRAME_SKIP) begin
        frame_skip_r <= pwdata[7:0];
      end
      if (idx == ccds_pkg::IDX_UPDATE) begin
        // Only the hold bit is writable; version stays fixed
        upd_r <= (upd_r & ~ccds_pkg::UPD_WR_MASK) | (pwdata[7:0] & ccds_pkg::UPD_WR_MASK);
      end
    end
  end

  ccds_gain_apply #(.W(8), .RST_VAL(ccds_pkg::RST_C1_ADC)) u_c1_adc (
    .clk_sys(clk_sys),
    .rst(rst),
    .hold(hold),
    .written(c1_adc_r),
    .active(c1_adc_act),
    .pending()
  );

  ccds_gain_apply #(.W(8), .RST_VAL(ccds_pkg::RST_DAC)) u_c1_dac (
    .clk_sys(clk_sys),
    .rst(rst),
    .hold(hold),
    .written(c1_dac_r),
    .active(c1_dac_act),
    .pending()
  );

  ccds_gain_apply #(.W(8), .RST_VAL(ccds_pkg::RST_C2_ADC)) u_c2_adc (
    .clk_sys(clk_sys),
    .rst(rst),
    .hold(hold),
    .written(c2_adc_r),
    .active(c2_adc_act),
    .pending()
  );

  ccds_gain_apply #(.W(8), .RST_VAL(ccds_pkg::RST_DAC)) u_c2_dac (
    .clk_sys(clk_sys),
    .rst(rst),
    .hold(hold),
    .written(c2_dac_r),
    .active(c2_dac_act),
    .pending()
  );

  ccds_gain_apply #(.W(8), .RST_VAL(ccds_pkg::RST_AMP)) u_amp (
    .clk_sys(clk_sys),
    .rst(rst),
    .hold(hold),
    .written(amp_r),
    .active(amp_act),
    .pending()
  );

  // Control-frame pacing: frame with control, then frame_skip_r frames without
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      skip_cnt_r <= 8'h00;
      ctrl_frame_r <= 1'b1;
    end else if (frame_sync) begin
      if (skip_cnt_r == 8'h00) begin
        ctrl_frame_r <= 1'b1;
        skip_cnt_r <= frame_skip_r;
      end else begin
        ctrl_frame_r <= 1'b0;
        skip_cnt_r <= skip_cnt_r - 8'h01;
      end
    end
  end

  // Settings outputs registered so every port comes from a flop
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      set_c1_ctrl_r <= ccds_pkg::RST_CTRL;
      set_c2_ctrl_r <= ccds_pkg::RST_CTRL;
      set_c1_adc_r <= ccds_pkg::RST_C1_ADC;
      set_c1_dac_r <= ccds_pkg::RST_DAC;
      set_c1_out_r <= ccds_pkg::RST_C1_OUT;
      set_c2_adc_r <= ccds_pkg::RST_C2_ADC;
      set_c2_dac_r <= ccds_pkg::RST_DAC;
      set_c2_out_r <= ccds_pkg::RST_C2_OUT;
      set_amp_r <= ccds_pkg::RST_AMP;
      set_clk_r <= ccds_pkg::RST_CLK;
      set_mic_spk_r <= ccds_pkg::RST_MIC_SPK;
      set_line_r <= ccds_pkg::RST_LINE;
      set_c1_mode_r <= ccds_pkg::RST_MODE;
      set_c2_mode_r <= ccds_pkg::RST_MODE;
    end else begin
      set_c1_ctrl_r <= c1_ctrl_r;
      set_c2_ctrl_r <= c2_ctrl_r;
      set_c1_adc_r <= c1_adc_act;
      set_c1_dac_r <= c1_dac_act;
      set_c1_out_r <= c1_out_r;
      set_c2_adc_r <= c2_adc_act;
      set_c2_dac_r <= c2_dac_act;
      set_c2_out_r <= c2_out_r;
      set_amp_r <= amp_act;
      set_clk_r <= clk_r;
      set_mic_spk_r <= mic_spk_r;
      set_line_r <= line_r;
      set_c1_mode_r <= c1_mode_r;
      set_c2_mode_r <= c2_mode_r;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign ctrl_frame = ctrl_frame_r;
  assign set_c1_ctrl = set_c1_ctrl_r;
  assign set_c2_ctrl = set_c2_ctrl_r;
  assign set_c1_adc = set_c1_adc_r;
  assign set_c1_dac = set_c1_dac_r;
  assign set_c1_out = set_c1_out_r;
  assign set_c2_adc = set_c2_adc_r;
  assign set_c2_dac = set_c2_dac_r;
  assign set_c2_out = set_c2_out_r;
  assign set_amp = set_amp_r;
  assign set_clk = set_clk_r;
  assign set_mic_spk = set_mic_spk_r;
  assign set_line = set_line_r;
  assign set_c1_mode = set_c1_mode_r;
  assign set_c2_mode = set_c2_mode_r;

endmodule : ccds_config_regs
`default_nettype wire

// ===== rtl/ccds_gain_apply.sv
// Holds the working copy of one gain register, frozen while updates are held
`timescale 1ns/10ps
`default_nettype none
module ccds_gain_apply #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Control
  input wire logic hold,
  input wire logic [W-1:0] written,
  // Working value
  output logic [W-1:0] active,
  output logic pending
);

  logic [W-1:0] active_r;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      active_r <= RST_VAL;
    end else if (!hold) begin
      active_r <= written;
    end
  end

  assign active = active_r;
  assign pending = (active_r != written);

endmodule : ccds_gain_apply
`default_nettype wire

// ===== rtl/ccds_pkg.sv
// Register map, reset defaults and field positions of the codec configuration block
`default_nettype none
package ccds_pkg;

  // Register indices; byte address is four times the index
  localparam int REG_FIRST = 1;
  localparam int REG_LAST = 21;
  localparam logic [4:0] IDX_C1_CTRL = 5'd1;
  localparam logic [4:0] IDX_C1_ADC = 5'd3;
  localparam logic [4:0] IDX_C1_DAC = 5'd4;
  localparam logic [4:0] IDX_C1_OUT = 5'd5;
  localparam logic [4:0] IDX_C2_CTRL = 5'd7;
  localparam logic [4:0] IDX_C2_ADC = 5'd8;
  localparam logic [4:0] IDX_C2_DAC = 5'd9;
  localparam logic [4:0] IDX_C2_OUT = 5'd10;
  localparam logic [4:0] IDX_AMP = 5'd11;
  localparam logic [4:0] IDX_CLK = 5'd12;
  localparam logic [4:0] IDX_MIC_SPK = 5'd13;
  localparam logic [4:0] IDX_LINE = 5'd14;
  localparam logic [4:0] IDX_C1_MODE = 5'd15;
  localparam logic [4:0] IDX_C2_MODE = 5'd16;
  localparam logic [4:0] IDX_FRAME_SKIP = 5'd17;
  localparam logic [4:0] IDX_RSVD_LO = 5'd18;
  localparam logic [4:0] IDX_RSVD_HI = 5'd20;
  localparam logic [4:0] IDX_UPDATE = 5'd21;

  // Codec control fields (registers 1 and 7)
  localparam int CTRL_SOFT_RESET = 7;
  localparam int CTRL_POWER_DOWN = 6;
  localparam int CTRL_ANA_LOOP = 5;
  localparam int CTRL_DIG_LOOP = 4;
  localparam logic [3:0] I_VALUE_RST = 4'h6;

  // Path and gain codes
  localparam logic [3:0] PGA_0DB = 4'h0;
  localparam logic [2:0] PATH_HANDSET = 3'h1;
  localparam logic [2:0] PATH_LINE = 3'h4;
  localparam logic [2:0] PREAMP_14DB = 3'h2;
  localparam logic [2:0] MIC_32DB = 3'h4;
  localparam logic [3:0] ECHO_M12DB = 4'h6;
  localparam logic [2:0] MCLK_24M576 = 3'h0;
  localparam logic [3:0] FRAME_SYNC_8K = 4'h0;

  // Register 21 fields
  localparam int UPD_HOLD_BIT = 2;
  localparam logic [7:0] UPD_WR_MASK = 8'h04;

  // Reset values
  localparam logic [7:0] RST_CTRL = {4'h0, I_VALUE_RST};
  localparam logic [7:0] RST_C1_ADC = {PGA_0DB, 1'b0, PATH_HANDSET};
  localparam logic [7:0] RST_DAC = {PGA_0DB, 4'h0};
  localparam logic [7:0] RST_C1_OUT = {5'h00, PATH_HANDSET};
  localparam logic [7:0] RST_C2_ADC = {PGA_0DB, 1'b0, PATH_LINE};
  localparam logic [7:0] RST_C2_OUT = {5'h00, PATH_LINE};
  // Handset out en, headset out en, handset preamp, headset preamp
  localparam logic [7:0] RST_AMP = {1'b1, 1'b1, PREAMP_14DB, PREAMP_14DB};
  // Data-valid flag enable, master clock select, frame_sync select
  localparam logic [7:0] RST_CLK = {1'b1, MCLK_24M576, FRAME_SYNC_8K};
  // Speaker power-down, mic gain, handset echo gain
  localparam logic [7:0] RST_MIC_SPK = {1'b1, MIC_32DB, ECHO_M12DB};
  // Line in en, line out en, common_mode_reference en, analog power-down, headset echo gain
  localparam logic [7:0] RST_LINE = {1'b1, 1'b1, 1'b1, 1'b0, ECHO_M12DB};
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_FRAME_SKIP = 8'h00;
  localparam logic [7:0] RST_UPD_LOW = 8'h08;
  localparam logic [3:0] VERSION_DEFAULT = 4'h1;

  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

endpackage : ccds_pkg
`default_nettype wire

// ===== verif/ccds_config_props.sv
// Port-level checks of the codec configuration register block
`timescale 1ns/10ps
`default_nettype none
module ccds_config_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Frame timing
  input wire logic frame_sync,
  input wire logic ctrl_frame,
  // Settings
  input wire logic [7:0] set_c1_ctrl,
  input wire logic [7:0] set_c2_ctrl,
  input wire logic [7:0] set_c1_adc,
  input wire logic [7:0] set_c1_dac,
  input wire logic [7:0] set_c2_adc,
  input wire logic [7:0] set_c2_out,
  input wire logic [7:0] set_amp,
  input wire logic [7:0] set_clk,
  input wire logic [7:0] set_mic_spk,
  input wire logic [7:0] set_line
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_pulse;
    pready ##1 !pready;
  endsequence
  property p_rdy_lat;
    s_access |=> s_pulse;
  endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("pready late or too long");
  property p_rdy_idle;
    !(psel && penable) |=> !pready;
  endproperty
  a_rdy_idle: assert property (p_rdy_idle) else $error("pready without access");
  property p_err_rdy;
    pslverr |-> pready && prdata == 32'h0000_0000;
  endproperty
  a_err_rdy: assert property (p_err_rdy) else $error("pslverr outside answer");
  property p_frame_stand;
    !frame_sync |=> $stable(ctrl_frame);
  endproperty
  a_frame_stand: assert property (p_frame_stand) else $error("ctrl_frame moved");
  // Reset checks run through reset itself, so no disable
  property p_rst_codec;
    disable iff (1'b0) rst |=> set_c1_ctrl == 8'h06 && set_c2_ctrl == 8'h06 && set_c1_adc == 8'h01
      && set_c1_dac == 8'h00 && set_c2_adc == 8'h04 && set_c2_out == 8'h04;
  endproperty
  a_rst_codec: assert property (p_rst_codec) else $error("codec defaults wrong");
  property p_rst_misc;
    disable iff (1'b0) rst |=> set_amp == 8'hD2 && set_clk == 8'h80 && set_mic_spk == 8'hC6
      && set_line == 8'hE6 && ctrl_frame;
  endproperty
  a_rst_misc: assert property (p_rst_misc) else $error("misc defaults wrong");
  property p_clk_wr;
    $changed(set_clk) |-> $past(pready && pwrite, 2);
  endproperty
  a_clk_wr: assert property (p_clk_wr) else $error("set_clk moved unwritten");
  property p_ctrl_wr;
    $changed(set_c1_ctrl) |-> $past(pready && pwrite, 2);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("set_c1_ctrl moved unwritten");
endmodule : ccds_config_props
bind ccds_config_regs ccds_config_props u_props (.clk_sys(clk_sys), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_sync(frame_sync), .ctrl_frame(ctrl_frame), .set_c1_ctrl(set_c1_ctrl),
  .set_c2_ctrl(set_c2_ctrl), .set_c1_adc(set_c1_adc), .set_c1_dac(set_c1_dac),
  .set_c2_adc(set_c2_adc), .set_c2_out(set_c2_out), .set_amp(set_amp), .set_clk(set_clk),
  .set_mic_spk(set_mic_spk), .set_line(set_line));
`default_nettype wire

// ===== verif/ccds_config_regs_tb.sv
// Self-checking bench for the codec configuration register block
`timescale 1ns/10ps
`default_nettype none
module ccds_config_regs_tb;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic frame_sync = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, ctrl_frame;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [7:0] sv [1:16];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #4 clk_sys = ~clk_sys;
  ccds_host_model host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  ccds_config_regs dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sync(frame_sync), .ctrl_frame(ctrl_frame), .set_c1_ctrl(sv[1]), .set_c2_ctrl(sv[7]),
    .set_c1_adc(sv[3]), .set_c1_dac(sv[4]), .set_c1_out(sv[5]), .set_c2_adc(sv[8]), .set_c2_dac(sv[9]),
    .set_c2_out(sv[10]), .set_amp(sv[11]), .set_clk(sv[12]), .set_mic_spk(sv[13]), .set_line(sv[14]),
    .set_c1_mode(sv[15]), .set_c2_mode(sv[16]));
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic wr(input int i, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, 8'(i * 4), 32'(d), 4'hF, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, a, 32'h0000_0000, 4'hF, r, e);
    chk("prdata", 32'(x), r);
    chk("pslverr", 32'(xe), 32'(e));
  endtask : rd
  task automatic t_reset;
    int ix [14] = '{1, 3, 4, 5, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16};
    // Codec control, paths, gains, amps, clocks, echo, line and reference
    logic [7:0] ev [14] = '{8'h06, 8'h01, 8'h00, 8'h01, 8'h06, 8'h04, 8'h00, 8'h04,
                            8'hD2, 8'h80, 8'hC6, 8'hE6, 8'h00, 8'h00};
    for (int k = 0; k < 14; k++) begin
      chk("set", 32'(ev[k]), 32'(sv[ix[k]]));
      rd(8'(ix[k] * 4), ev[k], 1'b0);
    end
    chk("ctrl_frame", 32'h0000_0001, 32'(ctrl_frame));
    $display("test reset done");
  endtask : t_reset
  task automatic t_map;
    // Pacing, reserved, update, unmapped, misaligned, beyond map
    logic [7:0] ad [7] = '{8'h44, 8'h48, 8'h54, 8'h08, 8'h05, 8'h58, 8'h00};
    logic [7:0] ex [7] = '{8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [6:0] er = 7'h0F;
    for (int k = 0; k < 7; k++) begin
      rd(ad[k], ex[k], er[6 - k]);
    end
    $display("test map done");
  endtask : t_map
  task automatic t_seq;
    int si [23] = '{11, 13, 14,
                    12, 1, 7,
                    3, 5, 8, 10, 15, 16,
                    3, 4, 8, 9, 11, 13, 12,
                    17, 11, 13, 14};
    logic [7:0] sd [23] = '{8'h12, 8'hC6, 8'hA6, 8'h91, 8'h05, 8'h03, 8'h04, 8'h04, 8'h01, 8'h01,
                            8'h80, 8'hC0, 8'h34, 8'h50, 8'h21, 8'h70, 8'h1B, 8'hC5, 8'h92,
                            8'h02, 8'hDB, 8'h45, 8'hE6};
    for (int k = 0; k < 23; k++) begin
      wr(si[k], sd[k]);
      repeat (3) @(posedge clk_sys);
      if (si[k] != 17) chk("set", 32'(sd[k]), 32'(sv[si[k]]));
    end
    $display("test sequence done");
  endtask : t_seq
  task automatic t_hold;
    wr(21, 8'hFF);
    rd(8'h54, 8'h1C, 1'b0);
    wr(3, 8'h77);
    repeat (3) @(posedge clk_sys);
    chk("set_c1_adc", 32'h0000_0034, 32'(sv[3]));
    wr(21, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("set_c1_adc", 32'h0000_0077, 32'(sv[3]));
    $display("test hold done");
  endtask : t_hold
  task automatic t_strobe;
    logic [31:0] r;
    logic e;
    // Lane 0 off: the write is dropped without an error
    host.xfer(1'b1, 8'h30, 32'h0000_00AA, 4'hE, r, e);
    chk("pslverr", 32'h0000_0000, 32'(e));
    repeat (3) @(posedge clk_sys);
    chk("set_clk", 32'h0000_0092, 32'(sv[12]));
    $display("test strobe done");
  endtask : t_strobe
  task automatic pulse(input logic x);
    frame_sync <= 1'b1;
    @(posedge clk_sys);
    frame_sync <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("ctrl_frame", 32'(x), 32'(ctrl_frame));
  endtask : pulse
  task automatic t_frame;
    logic [5:0] pat = 6'b100_100;
    // Pacing value 2 was left by the sequence
    for (int k = 5; k >= 0; k--) pulse(pat[k]);
    wr(17, 8'h00);
    pulse(1'b1);
    pulse(1'b1);
    rst <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    chk("set_clk", 32'h0000_0080, 32'(sv[12]));
    $display("test frame and reset done");
  endtask : t_frame
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    host.boot_wait();
    t_reset();
    t_map();
    t_seq();
    t_hold();
    t_strobe();
    t_frame();
    end_of_test();
  end
endmodule : ccds_config_regs_tb
`default_nettype wire

// ===== verif/ccds_host_model.sv
// Host-side APB master keeping the recommended write discipline
`timescale 1ns/10ps
`default_nettype none
module ccds_host_model (
  // Clock
  input wire logic clk_sys,
  // APB master
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb = 4'h0;
  end
  task automatic boot_wait;
    repeat (1250) @(posedge clk_sys);
  endtask : boot_wait
  // Called just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    // No own limit: only the bench timeout ends a stuck access
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines stop showing the old value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask : xfer
endmodule : ccds_host_model
`default_nettype wire
